//--- bfs_ceil_div.sv
/*
  Sequential divider giving the quotient rounded up to a whole number.
  Assumes start is a one-cycle pulse; a new start abandons any division
  under way, but a division whose last step ends on the edge that issues start
  still shows done with its stale quotient for one cycle.
  A zero divisor gives all ones so a batch never ends early.
*/
`timescale 1ns/1ps
module bfs_ceil_div import bfs_pkg::*; #(parameter int W = BFS_W) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Request
  input  wire logic         start,
  input  wire logic [W-1:0] num,
  input  wire logic [W-1:0] den,
  // Answer
  output logic              done,
  output logic [W-1:0]      quot
);

  typedef struct packed {
    logic                 busy;
    logic [$clog2(W):0]   cnt;
    logic [W:0]           rem;
    logic [W-1:0]         q;
    logic [W-1:0]         d;
    logic                 done;
    logic [W-1:0]         quot;
  } bfs_div_t;

  bfs_div_t s, next_s;
  logic [W:0] shifted;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    shifted = {s.rem[W-1:0], s.q[W-1]};
    if (start) begin
      next_s.busy = 1'b1;
      next_s.cnt  = '0;
      next_s.rem  = '0;
      next_s.q    = num;
      next_s.d    = den;
    end else if (s.busy) begin
      next_s.q = {s.q[W-2:0], 1'b0};
      if (shifted >= {1'b0, s.d}) begin
        next_s.rem  = shifted - {1'b0, s.d};
        next_s.q[0] = 1'b1;
      end else begin
        next_s.rem = shifted;
      end
      next_s.cnt = s.cnt + 1'b1;
      if (s.cnt == ($clog2(W) + 1)'(W - 1)) begin
        next_s.busy = 1'b0;
        next_s.done = 1'b1;
        // A remainder left over costs one more pack
        if (s.d == '0)
          next_s.quot = '1;
        else
          next_s.quot = next_s.q + W'(next_s.rem != '0);
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign done = s.done;
  assign quot = s.quot;

endmodule

//--- bfs_ctl_host.sv
/*
  Controller end: software drives run, mode, keys and entries over
  AXI4-Lite and reads the sequencer status back.
  Assumes the sequencer shares aclk; one write and one read at a time.
*/
`timescale 1ns/1ps
module bfs_ctl_host import bfs_pkg::*; #(parameter int W = BFS_W) (
  // Clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // AXI4-Lite write
  input  wire logic [BFS_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [BFS_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Sequencer link
  bfs_if.ctl                     seq
);

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    for (int i = 0; i < 4; i++)
      merge[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
  endfunction

  function automatic logic [BFS_AW-1:0] word(input logic [BFS_AW-1:0] a);
    word = {a[BFS_AW-1:2], 2'b00};
  endfunction

  typedef struct packed {
    logic              aw_got;
    logic [BFS_AW-1:0] aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [31:0]       ctrl;
    logic [31:0]       entry;
    logic [31:0]       target;
    logic [3:0]        keys;
    logic [W-1:0]      shown;
    logic              shown_flag;
  } bfs_host_t;

  bfs_host_t   s, next_s;
  logic [31:0] wv;
  logic [31:0] stat;
  logic        clr_shown;

  // ----------------------------------------
  // Register access
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.keys = '0;
    clr_shown = 1'b0;
    wv = '0;
    stat = '0;
    stat[STAT_END]   = seq.batch_end;
    stat[STAT_READY] = seq.ready_status;
    stat[STAT_BUSY]  = seq.busy;
    stat[STAT_SHOWN] = s.shown_flag;

    if (s_axi_awvalid && !s.aw_got) begin
      next_s.aw_got  = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_got) begin
      next_s.w_got  = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      next_s.bvalid = 1'b0;

    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = RESP_OKAY;
      unique case (word(s.aw_addr))
        REG_CTRL: begin
          wv = merge(s.ctrl, s.w_data, s.w_strb);
          next_s.ctrl = wv;
        end
        REG_KEY: begin
          // Key writes are pulses; nothing is kept
          wv = merge('0, s.w_data, s.w_strb);
          next_s.keys = wv[3:0];
        end
        REG_ENTRY:  next_s.entry  = merge(s.entry, s.w_data, s.w_strb);
        REG_TARGET: next_s.target = merge(s.target, s.w_data, s.w_strb);
        REG_STATUS, REG_SHOWN: ;
        default:    next_s.bresp  = RESP_SLVERR;
      endcase
    end

    if (s.rvalid && s_axi_rready)
      next_s.rvalid = 1'b0;
    if (s_axi_arvalid && !s.rvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = RESP_OKAY;
      next_s.rdata  = '0;
      unique case (word(s_axi_araddr))
        REG_CTRL:   next_s.rdata = s.ctrl;
        REG_ENTRY:  next_s.rdata = s.entry;
        REG_TARGET: next_s.rdata = s.target;
        REG_STATUS: next_s.rdata = stat;
        REG_SHOWN: begin
          next_s.rdata = 32'(s.shown);
          clr_shown = 1'b1;
        end
        REG_KEY: ;
        default:    next_s.rresp = RESP_SLVERR;
      endcase
    end

    // A new shown value wins over the clear by reading it
    if (clr_shown)
      next_s.shown_flag = 1'b0;
    if (seq.shown_valid) begin
      next_s.shown      = seq.shown_value;
      next_s.shown_flag = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Ports
  // ----------------------------------------
  assign s_axi_awready = !s.aw_got;
  assign s_axi_wready  = !s.w_got;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rresp   = s.rresp;
  assign s_axi_rdata   = s.rdata;

  assign seq.run_enable        = s.ctrl[CTRL_RUN];
  assign seq.batch_mode_select = bfs_mode_t'(s.ctrl[CTRL_MODE +: 2]);
  assign seq.batch_count_key   = s.keys[KEY_COUNT];
  assign seq.batch_weight_key  = s.keys[KEY_WEIGHT];
  assign seq.entry_valid       = s.keys[KEY_ENTRY];
  assign seq.single_start      = s.keys[KEY_START];
  assign seq.entry_value       = s.entry[W-1:0];
  assign seq.target_weight     = s.target[W-1:0];

endmodule

//--- bfs_if.sv
/*
  Link between the controller end and the batch sequencer.
  Assumes both ends run on the same clock; no crossing inside.
*/
`timescale 1ns/1ps
interface bfs_if import bfs_pkg::*; #(parameter int W = BFS_W);

  // Controller to sequencer
  logic            run_enable;
  bfs_mode_t       batch_mode_select;
  logic            batch_count_key;
  logic            batch_weight_key;
  logic            entry_valid;
  logic [W-1:0]    entry_value;
  logic [W-1:0]    target_weight;
  logic            single_start;
  // Sequencer to controller
  logic            ready_status;
  logic            busy;
  logic            batch_end;
  logic [W-1:0]    shown_value;
  logic            shown_valid;

  modport dev (
    input  run_enable, batch_mode_select, batch_count_key,
    input  batch_weight_key, entry_valid, entry_value,
    input  target_weight, single_start,
    output ready_status, busy, batch_end, shown_value, shown_valid
  );

  modport ctl (
    output run_enable, batch_mode_select, batch_count_key,
    output batch_weight_key, entry_valid, entry_value,
    output target_weight, single_start,
    input  ready_status, busy, batch_end, shown_value, shown_valid
  );

endinterface

//--- bfs_pkg.sv
/*
  Shared constants and types for the batch fill sequencer and its
  controller end. Assumes nothing of its surroundings.
*/
package bfs_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int BFS_W  = 24;
  localparam int BFS_AW = 5;

  // ----------------------------------------
  // Batch modes; single has no recipe slot, the others one each
  // ----------------------------------------
  typedef enum logic [1:0] {
    MODE_SINGLE,
    MODE_COUNT,
    MODE_TOTAL,
    MODE_BULK
  } bfs_mode_t;

  localparam logic [1:0] SLOT_COUNT = 2'h0;
  localparam logic [1:0] SLOT_TOTAL = 2'h1;
  localparam logic [1:0] SLOT_BULK  = 2'h2;

  // ----------------------------------------
  // Controller register map (byte offsets)
  // ----------------------------------------
  localparam logic [BFS_AW-1:0] REG_CTRL   = 5'h00;
  localparam logic [BFS_AW-1:0] REG_KEY    = 5'h04;
  localparam logic [BFS_AW-1:0] REG_ENTRY  = 5'h08;
  localparam logic [BFS_AW-1:0] REG_TARGET = 5'h0c;
  localparam logic [BFS_AW-1:0] REG_STATUS = 5'h10;
  localparam logic [BFS_AW-1:0] REG_SHOWN  = 5'h14;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_RUN   = 0;
  localparam int CTRL_MODE  = 1;
  localparam int KEY_COUNT  = 0;
  localparam int KEY_WEIGHT = 1;
  localparam int KEY_ENTRY  = 2;
  localparam int KEY_START  = 3;
  localparam int STAT_END   = 0;
  localparam int STAT_READY = 1;
  localparam int STAT_BUSY  = 2;
  localparam int STAT_SHOWN = 3;

  // ----------------------------------------
  // Bus responses
  // ----------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- bfs_seq_assertions.sv
/*
  Checker on the link between controller and sequencer.
  Assumes one clock; the bench instantiates it beside the link.
*/
`timescale 1ns/1ps
module bfs_seq_assertions (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link
  input wire logic run_enable,
  input wire logic batch_count_key,
  input wire logic batch_weight_key,
  input wire logic entry_valid,
  input wire logic ready_status,
  input wire logic busy,
  input wire logic batch_end,
  input wire logic shown_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_end_alone;
    batch_end |-> !busy && !ready_status;
  endproperty
  a_end_alone: assert property (p_end_alone)
    else $error("end raised beside busy or ready");
  property p_end_hold;
    batch_end && run_enable |=> batch_end;
  endproperty
  a_end_hold: assert property (p_end_hold)
    else $error("end dropped while run high");
  property p_end_exit;
    $fell(batch_end) |-> ready_status && !$past(run_enable);
  endproperty
  a_end_exit: assert property (p_end_exit)
    else $error("end left without run low");
  property p_abort;
    busy && !run_enable |=> ready_status;
  endproperty
  a_abort: assert property (p_abort)
    else $error("fill kept going with run low");
  // Run low at ready must never launch anything
  property p_no_start;
    ready_status && !run_enable |=> !busy && !batch_end;
  endproperty
  a_no_start: assert property (p_no_start)
    else $error("batch began without run");
  property p_start_cause;
    $rose(busy) |-> $past(run_enable);
  endproperty
  a_start_cause: assert property (p_start_cause)
    else $error("busy rose without run");
  property p_key_show;
    batch_count_key && !entry_valid |=> shown_valid;
  endproperty
  a_key_show: assert property (p_key_show)
    else $error("count key gave no display");
  property p_show_cause;
    shown_valid |-> $past(batch_count_key || batch_weight_key);
  endproperty
  a_show_cause: assert property (p_show_cause)
    else $error("display without a key");
endmodule

//--- bfs_seq_dev.sv
/*
  Batch fill sequencer: repeats single-pack fills under the run input
  until a pack count, a batch total or a bulk total is met.
  Assumes the fill engine answers each fill_start with one fill_done
  pulse and the controller holds target_weight steady during a batch.
*/
`timescale 1ns/1ps
module bfs_seq_dev import bfs_pkg::*; #(parameter int W = BFS_W) (
  // Clock and reset
  input  wire logic         aclk,
  input  wire logic         aresetn,
  // Controller link
  bfs_if.dev                ctl,
  // Fill engine
  output logic              fill_start,
  output logic [W-1:0]      fill_target,
  input  wire logic         fill_done,
  input  wire logic [W-1:0] filled_weight,
  // End output
  output logic              end_out
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] slot_of(input bfs_mode_t m);
    unique case (m)
      MODE_TOTAL: slot_of = SLOT_TOTAL;
      MODE_BULK:  slot_of = SLOT_BULK;
      default:    slot_of = SLOT_COUNT;
    endcase
  endfunction

  // Negative remainders read as zero on display and as a target
  function automatic logic [W-1:0] clip(input logic signed [W:0] v);
    clip = v[W] ? '0 : v[W-1:0];
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [2:0] {
    S_READY,
    S_CALC,
    S_REQ,
    S_WAIT,
    S_DONE
  } bfs_state_t;

  typedef struct packed {
    bfs_state_t         st;
    bfs_mode_t          mode;
    logic [2:0][W-1:0]  rcp;
    logic [W-1:0]       rem_cnt;
    logic signed [W:0]  rem_wt;
    logic               fill_start;
    logic [W-1:0]       fill_target;
    logic [W-1:0]       shown;
    logic               shown_valid;
    logic               div_go;
    logic [W-1:0]       div_num;
  } bfs_dev_t;

  bfs_dev_t          s, next_s;
  logic              div_done;
  logic [W-1:0]      div_quot;
  logic signed [W:0] tgt_s;
  logic signed [W:0] after_fill;
  logic [1:0]        sel_slot;

  bfs_ceil_div #(.W(W)) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (s.div_go),
    .num     (s.div_num),
    .den     (ctl.target_weight),
    .done    (div_done),
    .quot    (div_quot)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_s = s;
    next_s.fill_start  = 1'b0;
    next_s.shown_valid = 1'b0;
    next_s.div_go      = 1'b0;
    tgt_s      = $signed({1'b0, ctl.target_weight});
    after_fill = s.rem_wt - $signed({1'b0, filled_weight});
    sel_slot   = slot_of(ctl.batch_mode_select);

    // Key presses without an entry only show a value
    if (ctl.batch_count_key && !ctl.entry_valid) begin
      next_s.shown_valid = 1'b1;
      if (s.st == S_READY)
        next_s.shown = s.rcp[SLOT_COUNT];
      else
        next_s.shown = s.rem_cnt;
    end else if (ctl.batch_weight_key && !ctl.entry_valid) begin
      next_s.shown_valid = 1'b1;
      if (s.st == S_READY)
        next_s.shown = s.rcp[sel_slot];
      else
        next_s.shown = clip(s.rem_wt);
    end

    unique case (s.st)
      S_READY: begin
        if (ctl.entry_valid && ctl.batch_count_key &&
            ctl.batch_mode_select == MODE_COUNT)
          next_s.rcp[SLOT_COUNT] = ctl.entry_value;
        if (ctl.entry_valid && ctl.batch_weight_key &&
            (ctl.batch_mode_select == MODE_TOTAL ||
             ctl.batch_mode_select == MODE_BULK))
          next_s.rcp[sel_slot] = ctl.entry_value;
        if (ctl.run_enable) begin
          next_s.mode = ctl.batch_mode_select;
          unique case (ctl.batch_mode_select)
            MODE_SINGLE: begin
              // Single starts are honoured in single mode only
              if (ctl.single_start) begin
                next_s.rem_cnt = W'(1);
                next_s.st      = S_REQ;
              end
            end
            MODE_COUNT: begin
              next_s.rem_cnt = s.rcp[SLOT_COUNT];
              if (s.rcp[SLOT_COUNT] == '0)
                next_s.st = S_DONE;
              else
                next_s.st = S_REQ;
            end
            MODE_TOTAL, MODE_BULK: begin
              next_s.rem_wt  = $signed({1'b0, s.rcp[sel_slot]});
              next_s.div_num = s.rcp[sel_slot];
              next_s.div_go  = 1'b1;
              next_s.st      = S_CALC;
            end
          endcase
        end
      end
      S_CALC: begin
        if (!ctl.run_enable) begin
          next_s.st = S_READY;
        end else if (div_done) begin
          next_s.rem_cnt = div_quot;
          if (s.mode == MODE_TOTAL && div_quot == '0)
            next_s.st = S_DONE;
          else if (s.mode == MODE_BULK && s.rem_wt <= 0)
            next_s.st = S_DONE;
          else
            next_s.st = S_REQ;
        end
      end
      S_REQ: begin
        if (!ctl.run_enable) begin
          next_s.st = S_READY;
        end else begin
          next_s.fill_start = 1'b1;
          if (s.mode == MODE_BULK && s.rem_wt < tgt_s)
            next_s.fill_target = clip(s.rem_wt);
          else
            next_s.fill_target = ctl.target_weight;
          next_s.st = S_WAIT;
        end
      end
      S_WAIT: begin
        if (!ctl.run_enable) begin
          next_s.st = S_READY;
        end else if (fill_done) begin
          next_s.rem_cnt = s.rem_cnt - 1'b1;
          next_s.rem_wt  = after_fill;
          unique case (s.mode)
            MODE_SINGLE: next_s.st = S_READY;
            MODE_COUNT, MODE_TOTAL: begin
              if (s.rem_cnt == W'(1))
                next_s.st = S_DONE;
              else
                next_s.st = S_REQ;
            end
            MODE_BULK: begin
              if (after_fill <= 0) begin
                next_s.st = S_DONE;
              end else begin
                // Recount packs left so the count key stays honest
                next_s.div_num = clip(after_fill);
                next_s.div_go  = 1'b1;
                next_s.st      = S_CALC;
              end
            end
          endcase
        end
      end
      S_DONE: begin
        // End holds until run drops, so a held run cannot rearm
        if (!ctl.run_enable)
          next_s.st = S_READY;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn)
      s <= '0;
    else
      s <= next_s;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign fill_start       = s.fill_start;
  assign fill_target      = s.fill_target;
  assign end_out          = (s.st == S_DONE);
  assign ctl.batch_end    = (s.st == S_DONE);
  assign ctl.ready_status = (s.st == S_READY);
  assign ctl.busy         = (s.st == S_CALC) || (s.st == S_REQ) ||
                            (s.st == S_WAIT);
  assign ctl.shown_value  = s.shown;
  assign ctl.shown_valid  = s.shown_valid;

endmodule

//--- testbench.sv
/*
  Bench: AXI4-Lite master, fill engine model, checker beside link.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps
module testbench import bfs_pkg::*;;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  logic [4:0]        awaddr = 5'h00;
  logic [4:0]        araddr = 5'h00;
  logic [31:0]       wdata = 32'h0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              fill_done = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              fill_start, end_out;
  logic [1:0]        bresp, rresp, rr;
  logic [31:0]       rdata, rv;
  logic [BFS_W-1:0]  fill_target;
  logic [BFS_W-1:0]  last_tgt = '0;
  int                fails = 0, num_checks = 0, cycles = 0;
  int                nfill = 0, dly = 0;
  // ----------------------------------------
  // Clock, timeout, fill engine
  // ----------------------------------------
  always #50 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // Each fill lands exactly on its target; delay lets keys hit mid-fill
  always @(posedge aclk) begin
    fill_done <= (dly == 1);
    if (fill_start) begin
      nfill <= nfill + 1;
      last_tgt <= fill_target;
      dly <= 8;
    end else if (dly != 0) begin
      dly <= dly - 1;
    end
  end
  bfs_if #(.W(BFS_W)) bfs_if_i ();
  bfs_seq_dev #(.W(BFS_W)) bfs_seq_dev_i (.aclk(aclk),
    .aresetn(aresetn), .ctl(bfs_if_i), .fill_start(fill_start),
    .fill_target(fill_target), .fill_done(fill_done),
    .filled_weight(last_tgt), .end_out(end_out));
  bfs_ctl_host #(.W(BFS_W)) bfs_ctl_host_i (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .seq(bfs_if_i));
  bfs_seq_assertions bfs_seq_assertions_i (.aclk(aclk),
    .aresetn(aresetn), .run_enable(bfs_if_i.run_enable),
    .batch_count_key(bfs_if_i.batch_count_key),
    .batch_weight_key(bfs_if_i.batch_weight_key),
    .entry_valid(bfs_if_i.entry_valid),
    .ready_status(bfs_if_i.ready_status), .busy(bfs_if_i.busy),
    .batch_end(bfs_if_i.batch_end), .shown_valid(bfs_if_i.shown_valid));
  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task chk(input string nm, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task wr(input logic [4:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    chk("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
    bready <= 1'b0;
  endtask
  task rd(input logic [4:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rv = rdata;
    rr = rresp;
    rready <= 1'b0;
  endtask
  task show(input logic [31:0] k, e);
    wr(REG_KEY, k);
    rd(REG_SHOWN);
    chk("shown", rv, e);
  endtask
  task wait_end;
    do rd(REG_STATUS); while (rv[STAT_END] !== 1'b1);
  endtask
  task batch(input logic [31:0] ctrl, n, lt, input logic wk);
    int n0;
    n0 = nfill;
    wr(REG_CTRL, ctrl);
    wait_end();
    chk("fills", nfill - n0, n);
    chk("end_out", {31'h0, end_out}, 32'h1);
    chk("last target", {8'h0, last_tgt}, lt);
    show(32'h1, 32'h0);
    if (wk) show(32'h2, 32'h0);
    wr(REG_CTRL, ctrl & 32'hfffffffe);
    rd(REG_STATUS);
    chk("status", {29'h0, rv[2:0]}, 32'h2);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task test_count;
    wr(REG_TARGET, 32'h5);
    wr(REG_CTRL, 32'h2);
    wr(REG_ENTRY, 32'h3);
    wr(REG_KEY, 32'h5);
    show(32'h1, 32'h3);
    batch(32'h3, 32'h3, 32'h5, 1'b0);
    $display("count test done");
  endtask
  // Ten over three rounds up to four packs
  task test_total;
    wr(REG_TARGET, 32'h3);
    wr(REG_CTRL, 32'h4);
    wr(REG_ENTRY, 32'ha);
    wr(REG_KEY, 32'h6);
    show(32'h2, 32'ha);
    batch(32'h5, 32'h4, 32'h3, 1'b1);
    $display("total test done");
  endtask
  // Bulk of ten: three full packs then a trimmed one of one
  task test_bulk;
    wr(REG_CTRL, 32'h6);
    wr(REG_ENTRY, 32'ha);
    wr(REG_KEY, 32'h6);
    batch(32'h7, 32'h4, 32'h1, 1'b1);
    $display("bulk test done");
  endtask
  task test_busy_entry;
    wr(REG_CTRL, 32'h2);
    show(32'h1, 32'h3);
    wr(REG_CTRL, 32'h3);
    wr(REG_ENTRY, 32'h9);
    wr(REG_KEY, 32'h5);
    wait_end();
    wr(REG_CTRL, 32'h2);
    show(32'h1, 32'h3);
    wr(REG_CTRL, 32'h3);
    wr(REG_CTRL, 32'h2);
    rd(REG_STATUS);
    chk("abort", {29'h0, rv[2:0]}, 32'h2);
    repeat (20) @(posedge aclk);
    batch(32'h3, 32'h3, 32'h3, 1'b0);
    rd(5'h18);
    chk("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
    $display("busy entry test done");
  endtask
  // Single fills run only in single mode, never beside a batch
  task test_single;
    int n0;
    n0 = nfill;
    wr(REG_CTRL, 32'h1);
    wr(REG_KEY, 32'h8);
    repeat (20) @(posedge aclk);
    chk("single fills", nfill - n0, 32'h1);
    rd(REG_STATUS);
    chk("single done", {29'h0, rv[2:0]}, 32'h2);
    wr(REG_CTRL, 32'h3);
    wait_end();
    wr(REG_KEY, 32'h8);
    repeat (20) @(posedge aclk);
    chk("start in batch", nfill - n0, 32'h4);
    chk("end held", {31'h0, end_out}, 32'h1);
    wr(REG_CTRL, 32'h0);
    $display("single test done");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    test_count();
    test_total();
    test_bulk();
    test_busy_entry();
    test_single();
    wrap_up();
  end
endmodule
